// ---- logic/ulm_mapper.sv ----
/*
 * Unstructured leased line mapper: packs the application bit stream into the
 * core frame and unpacks it again, drives overhead flags and section state.
 * Assumes the transceiver core accepts a byte whenever one is offered.
 */
// Register access over AHB-Lite and the address map were decided locally.
// Function
// - Carry the application bit stream unchanged inside a 144 byte core frame every 500 us.
// - Take exactly 128 payload bytes from the application side per core frame.
// - Fill the 16 remaining byte positions of each frame with all ones.
// - Send the spare overhead bits nine through forty-eight as constant ones.
// - Report the section operational only when all pairs are active, identified and healthy.
// - Report the section down as soon as any pair fails or is misidentified.
// - Never look into or alter the payload for maintenance purposes; the CTRL_FORCE control bit still forces all ones on the application output.
// - Replace the payload sent to the far end with all ones while the input is lost.
// - Drive the signal loss overhead flag to zero while the input is lost.
// - Before all transceivers are active the application output may carry any value.
// - Keep each unit's share of the one-way delay within 450 us of the 1250 us budget.
`timescale 1ns/1ps
module ulm_mapper #(
    parameter int unsigned N_PAIRS = 2,
    parameter int unsigned Q_DEPTH = 4
) (
    input  wire logic                          CLK,
    input  wire logic                          RST,
    input  wire logic                          HSEL,
    input  wire logic [31:0]                   HADDR,
    input  wire logic [1:0]                    HTRANS,
    input  wire logic                          HWRITE,
    input  wire logic [2:0]                    HSIZE,
    input  wire logic [31:0]                   HWDATA,
    input  wire logic                          HREADY,
    output logic      [31:0]                   HRDATA,
    output logic                               HREADYOUT,
    output logic                               HRESP,
    input  wire logic                          APP_RX_DATA,
    input  wire logic                          APP_LOS,
    output logic                               APP_BIT_EN,
    output logic                               APP_TX_DATA,
    output ulm_pkg::ulm_byte_t                 CORE_TX,
    output logic                               CORE_TX_LOSD,
    output logic      [39:0]                   CORE_TX_ZSPARE,
    input  wire ulm_pkg::ulm_byte_t            CORE_RX,
    input  wire ulm_pkg::ulm_pair_t [N_PAIRS-1:0] PAIR_STATUS,
    input  wire logic                          OTHER_FAIL,
    output logic                               SECTION_OPERATIONAL,
    output logic                               IRQ
);
    localparam int unsigned QW = $clog2(Q_DEPTH);

    function automatic logic is_stuff(input logic [3:0] grp);
        is_stuff = (grp == 4'(ulm_pkg::GROUP_LEN - 1));
    endfunction

    function automatic logic [3:0] grp_next(input logic [3:0] grp);
        grp_next = is_stuff(grp) ? 4'h0 : grp + 4'h1;
    endfunction

    logic        bit_en;
    logic        wr_stb;
    logic        rd_stb;
    logic [7:0]  reg_addr;

    logic [1:0]  ctrl_r;
    logic [4:0]  irq_sts_r;
    logic [4:0]  irq_sts_nxt;
    logic [4:0]  irq_msk_r;
    logic [15:0] frames_r;

    logic        app_los_r;
    logic        oper_nxt;
    logic        ais_nxt;
    logic [4:0]  events;

    logic [7:0]  tsh_r;
    logic [2:0]  tbc_r;
    logic [3:0]  tgrp_r;
    logic [7:0]  tidx_r;
    logic        stuff_pend_r;

    logic [3:0]  rgrp_r;
    logic [7:0]  q_mem_r [Q_DEPTH];
    logic [QW-1:0] q_wp_r;
    logic [QW-1:0] q_rp_r;
    logic [QW:0] q_cnt_r;
    logic        q_push;
    logic        q_pop;
    logic        q_ovf;
    logic [7:0]  osh_r;
    logic [2:0]  obc_r;
    logic [7:0]  obyte;

    ulm_rate_gen #(
        .NUM (ulm_pkg::APP_BIT_HZ / 1000),
        .DEN (ulm_pkg::CLK_HZ / 1000),
        .AW  (17)
    ) u_rate (
        .clk  (CLK),
        .rst  (RST),
        .tick (bit_en)
    );

    ulm_ahb_if u_ahb (
        .clk       (CLK),
        .rst       (RST),
        .hsel      (HSEL),
        .haddr     (HADDR),
        .htrans    (HTRANS),
        .hwrite    (HWRITE),
        .hready    (HREADY),
        .hreadyout (HREADYOUT),
        .wr_stb    (wr_stb),
        .rd_stb    (rd_stb),
        .addr      (reg_addr)
    );

    assign APP_BIT_EN = bit_en;

    always_comb begin
        oper_nxt = ~OTHER_FAIL;
        ais_nxt  = ctrl_r[ulm_pkg::CTRL_FORCE];
        for (int i = 0; i < N_PAIRS; i++) begin
            oper_nxt = oper_nxt & PAIR_STATUS[i].active & PAIR_STATUS[i].id_ok
                       & ~PAIR_STATUS[i].los & ~PAIR_STATUS[i].loss_of_frame_alignment;
            ais_nxt  = ais_nxt | PAIR_STATUS[i].los | PAIR_STATUS[i].loss_of_frame_alignment
                       | ~PAIR_STATUS[i].active;
        end
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            SECTION_OPERATIONAL <= 1'b0;
            app_los_r           <= 1'b0;
        end else begin
            SECTION_OPERATIONAL <= oper_nxt;
            app_los_r           <= APP_LOS;
        end
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            CORE_TX_LOSD   <= 1'b1;
            CORE_TX_ZSPARE <= ulm_pkg::ZSPARE_VALUE;
        end else begin
            CORE_TX_LOSD   <= ~APP_LOS;
            CORE_TX_ZSPARE <= ulm_pkg::ZSPARE_VALUE;
        end
    end

    always_ff @(posedge CLK) begin
        if (RST || !ctrl_r[ulm_pkg::CTRL_TX_EN]) begin
            tsh_r        <= 8'h00;
            tbc_r        <= 3'h0;
            tgrp_r       <= 4'h0;
            tidx_r       <= 8'h00;
            stuff_pend_r <= 1'b0;
            CORE_TX      <= '0;
        end else if (stuff_pend_r) begin
            CORE_TX.valid <= 1'b1;
            CORE_TX.first <= 1'b0;
            CORE_TX.data  <= ulm_pkg::STUFF_VALUE;
            stuff_pend_r  <= 1'b0;
            tgrp_r        <= grp_next(tgrp_r);
            tidx_r        <= (tidx_r == 8'(ulm_pkg::FRAME_BYTES - 1)) ? 8'h00 : tidx_r + 8'h01;
        end else if (bit_en) begin
            tsh_r <= {tsh_r[6:0], APP_RX_DATA | APP_LOS};
            tbc_r <= tbc_r + 3'h1;
            if (tbc_r == 3'h7) begin
                // Byte leaves one cycle after it completes.
                CORE_TX.valid <= 1'b1;
                CORE_TX.first <= (tidx_r == 8'h00);
                CORE_TX.data  <= {tsh_r[6:0], APP_RX_DATA | APP_LOS};
                tgrp_r        <= grp_next(tgrp_r);
                tidx_r        <= tidx_r + 8'h01;
                stuff_pend_r  <= is_stuff(grp_next(tgrp_r));
            end else begin
                CORE_TX.valid <= 1'b0;
                CORE_TX.first <= 1'b0;
            end
        end else begin
            CORE_TX.valid <= 1'b0;
            CORE_TX.first <= 1'b0;
        end
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            frames_r <= 16'h0000;
        end else if (stuff_pend_r && tidx_r == 8'(ulm_pkg::FRAME_BYTES - 1)) begin
            frames_r <= frames_r + 16'h0001;
        end
    end

    // Payload bytes pass opaque, stuffing dropped.
    assign q_push = CORE_RX.valid && !is_stuff(CORE_RX.first ? 4'h0 : rgrp_r);
    assign q_pop  = bit_en && (obc_r == 3'h0) && (q_cnt_r != '0);
    assign q_ovf  = q_push && !q_pop && (q_cnt_r == (QW+1)'(Q_DEPTH));
    assign obyte  = (q_cnt_r != '0) ? q_mem_r[q_rp_r] : ulm_pkg::STUFF_VALUE;

    always_ff @(posedge CLK) begin
        if (RST) begin
            rgrp_r <= 4'h0;
        end else if (CORE_RX.valid) begin
            rgrp_r <= grp_next(CORE_RX.first ? 4'h0 : rgrp_r);
        end
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            q_wp_r  <= '0;
            q_rp_r  <= '0;
            q_cnt_r <= '0;
        end else begin
            if (q_push && !q_ovf) begin
                q_mem_r[q_wp_r] <= CORE_RX.data;
                q_wp_r          <= q_wp_r + 1'b1;
            end
            if (q_pop) begin
                q_rp_r <= q_rp_r + 1'b1;
            end
            if (q_push && !q_ovf && !q_pop) begin
                q_cnt_r <= q_cnt_r + 1'b1;
            end else if (q_pop && !(q_push && !q_ovf)) begin
                q_cnt_r <= q_cnt_r - 1'b1;
            end
        end
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            osh_r       <= ulm_pkg::STUFF_VALUE;
            obc_r       <= 3'h0;
            APP_TX_DATA <= 1'b1;
        end else if (bit_en) begin
            obc_r <= obc_r + 3'h1;
            if (obc_r == 3'h0) begin
                osh_r       <= {obyte[6:0], 1'b1};
                APP_TX_DATA <= ais_nxt | obyte[7];
            end else begin
                osh_r       <= {osh_r[6:0], 1'b1};
                APP_TX_DATA <= ais_nxt | osh_r[7];
            end
        end
    end

    assign events[ulm_pkg::EV_LOS_SET]   = APP_LOS & ~app_los_r;
    assign events[ulm_pkg::EV_LOS_CLR]   = ~APP_LOS & app_los_r;
    assign events[ulm_pkg::EV_OPER_DOWN] = SECTION_OPERATIONAL & ~oper_nxt;
    assign events[ulm_pkg::EV_OPER_UP]   = ~SECTION_OPERATIONAL & oper_nxt;
    assign events[ulm_pkg::EV_RX_OVF]    = q_ovf;

    always_comb begin
        irq_sts_nxt = irq_sts_r;
        if (wr_stb && reg_addr == ulm_pkg::ADDR_IRQ_STS) begin
            irq_sts_nxt = irq_sts_nxt & ~HWDATA[ulm_pkg::EV_W-1:0];
        end
        irq_sts_nxt = irq_sts_nxt | events;
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            irq_sts_r <= 5'h00;
            IRQ       <= 1'b0;
        end else begin
            irq_sts_r <= irq_sts_nxt;
            IRQ       <= |(irq_sts_nxt & irq_msk_r);
        end
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            ctrl_r    <= ulm_pkg::CTRL_RESET;
            irq_msk_r <= ulm_pkg::MSK_RESET;
        end else if (wr_stb) begin
            if (reg_addr == ulm_pkg::ADDR_CTRL) begin
                ctrl_r <= HWDATA[1:0];
            end
            if (reg_addr == ulm_pkg::ADDR_IRQ_MSK) begin
                irq_msk_r <= HWDATA[ulm_pkg::EV_W-1:0];
            end
        end
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            HRDATA <= 32'h0000_0000;
            HRESP  <= 1'b0;
        end else if (rd_stb) begin
            unique case (reg_addr)
                ulm_pkg::ADDR_CTRL:    HRDATA <= {30'h0000_0000, ctrl_r};
                ulm_pkg::ADDR_STATUS:  HRDATA <= {28'h000_0000, CORE_TX_LOSD,
                                                  ais_nxt, app_los_r, SECTION_OPERATIONAL};
                ulm_pkg::ADDR_IRQ_STS: HRDATA <= {27'h000_0000, irq_sts_r};
                ulm_pkg::ADDR_IRQ_MSK: HRDATA <= {27'h000_0000, irq_msk_r};
                ulm_pkg::ADDR_FRAMES:  HRDATA <= {16'h0000, frames_r};
                default:               HRDATA <= 32'h0000_0000;
            endcase
        end
    end

endmodule

// ---- logic/ulm_pkg.sv ----
/*
 * Shared constants and carrier types for the unstructured leased line mapper.
 * Assumes a single 125 MHz clock and an AHB-Lite register bus.
 */
package ulm_pkg;

    localparam int unsigned CLK_HZ        = 125000000;
    localparam int unsigned APP_BIT_HZ    = 2048000;
    localparam int unsigned FRAME_US      = 500;
    localparam int unsigned FRAME_BYTES   = 144;
    localparam int unsigned PAYLOAD_BYTES = 128;
    localparam int unsigned STUFF_BYTES   = 16;
    localparam int unsigned GROUP_LEN     = FRAME_BYTES / STUFF_BYTES;
    localparam int unsigned TU_DELAY_US   = 450;
    localparam int unsigned PATH_DELAY_US = 1250;
    localparam int unsigned RPT_DELAY_US  = 200;

    localparam logic [7:0]  STUFF_VALUE   = 8'hFF;
    localparam logic [39:0] ZSPARE_VALUE  = 40'hFF_FFFF_FFFF;
    localparam int unsigned LOSD_BIT_NUM  = 15;

    localparam logic [7:0]  ADDR_CTRL     = 8'h00;
    localparam logic [7:0]  ADDR_STATUS   = 8'h04;
    localparam logic [7:0]  ADDR_IRQ_STS  = 8'h08;
    localparam logic [7:0]  ADDR_IRQ_MSK  = 8'h0C;
    localparam logic [7:0]  ADDR_FRAMES   = 8'h10;

    localparam int unsigned CTRL_TX_EN    = 0;
    localparam int unsigned CTRL_FORCE    = 1;
    localparam logic [1:0]  CTRL_RESET    = 2'h1;

    localparam int unsigned ST_OPER       = 0;
    localparam int unsigned ST_APP_LOS    = 1;
    localparam int unsigned ST_AIS        = 2;
    localparam int unsigned ST_LOSD       = 3;

    localparam int unsigned EV_LOS_SET    = 0;
    localparam int unsigned EV_LOS_CLR    = 1;
    localparam int unsigned EV_OPER_DOWN  = 2;
    localparam int unsigned EV_OPER_UP    = 3;
    localparam int unsigned EV_RX_OVF     = 4;
    localparam int unsigned EV_W          = 5;
    localparam logic [4:0]  MSK_RESET     = 5'h00;

    typedef struct packed {
        logic active;
        logic id_ok;
        logic los;
        logic loss_of_frame_alignment;
    } ulm_pair_t;

    typedef struct packed {
        logic       valid;
        logic       first;
        logic [7:0] data;
    } ulm_byte_t;

endpackage

// ---- logic/ulm_rate_gen.sv ----
/*
 * Fractional divider producing a one-cycle enable at NUM/DEN of the clock rate.
 * Assumes NUM is below DEN and both fit the accumulator.
 */
`timescale 1ns/1ps
module ulm_rate_gen #(
    parameter int unsigned NUM = 2048,
    parameter int unsigned DEN = 125000,
    parameter int unsigned AW  = 17
) (
    input  wire logic clk,
    input  wire logic rst,
    output logic      tick
);
    localparam logic [AW-1:0] NUM_W = AW'(NUM);
    localparam logic [AW-1:0] DEN_W = AW'(DEN);

    logic [AW:0] acc_r;
    logic [AW:0] sum;

    assign sum = acc_r + {1'b0, NUM_W};

    always_ff @(posedge clk) begin
        if (rst) begin
            acc_r <= '0;
            tick  <= 1'b0;
        end else if (sum >= {1'b0, DEN_W}) begin
            acc_r <= sum - {1'b0, DEN_W};
            tick  <= 1'b1;
        end else begin
            acc_r <= sum;
            tick  <= 1'b0;
        end
    end

endmodule

// ---- logic/ulm_ahb_if.sv ----
/*
 * AHB-Lite slave front end: captures address phases, strobes writes in the
 * data phase and inserts one wait state on reads. Assumes single word transfers.
 */
`timescale 1ns/1ps
module ulm_ahb_if (
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             wr_stb,
    output logic             rd_stb,
    output logic [7:0]       addr
);
    logic ph_valid_r;
    logic ph_write_r;

    assign wr_stb = ph_valid_r & ph_write_r;
    assign rd_stb = ph_valid_r & ~ph_write_r & ~hreadyout;

    always_ff @(posedge clk) begin
        if (rst) begin
            ph_valid_r <= 1'b0;
            ph_write_r <= 1'b0;
            addr       <= 8'h00;
            hreadyout  <= 1'b1;
        end else if (hready && hsel && htrans[1]) begin
            ph_valid_r <= 1'b1;
            ph_write_r <= hwrite;
            addr       <= haddr[7:0];
            hreadyout  <= hwrite;
        end else if (rd_stb) begin
            hreadyout  <= 1'b1;
        end else if (hreadyout) begin
            ph_valid_r <= 1'b0;
        end
    end

endmodule

// ---- bench/ulm_mapper_sva.sv ----
/* Port checker for the leased line mapper.
   Assumes it is bound to ulm_mapper with one clock and synchronous reset. */
`timescale 1ns/1ps
module ulm_mapper_sva #(
    parameter int unsigned N_PAIRS = 2
) (
    input wire logic                              CLK,
    input wire logic                              RST,
    input wire logic                              HSEL,
    input wire logic [1:0]                        HTRANS,
    input wire logic                              HWRITE,
    input wire logic                              HREADY,
    input wire logic                              HREADYOUT,
    input wire logic                              HRESP,
    input wire logic                              APP_LOS,
    input wire logic                              APP_BIT_EN,
    input wire logic                              APP_TX_DATA,
    input wire ulm_pkg::ulm_byte_t                CORE_TX,
    input wire logic                              CORE_TX_LOSD,
    input wire logic [39:0]                       CORE_TX_ZSPARE,
    input wire ulm_pkg::ulm_pair_t [N_PAIRS-1:0]  PAIR_STATUS,
    input wire logic                              OTHER_FAIL,
    input wire logic                              SECTION_OPERATIONAL
);
    localparam logic [9:0] LOS_SET = 10'h3E8;
    localparam logic [9:0] AIS_SET = 10'h064;
    logic [7:0] cnt_r;
    logic       seen_r;
    logic [9:0] los_cnt_r;
    logic [9:0] ais_cnt_r;
    logic       ok;
    logic       bad;
    logic       ais_cond;
    logic       rd_req;
    logic       wr_req;

    always_comb begin
        ok = !OTHER_FAIL;
        bad = 1'b0;
        ais_cond = 1'b0;
        for (int i = 0; i < N_PAIRS; i++) begin
            ok = ok && PAIR_STATUS[i].active && PAIR_STATUS[i].id_ok;
            ok = ok && !PAIR_STATUS[i].los && !PAIR_STATUS[i].loss_of_frame_alignment;
            bad = bad || !PAIR_STATUS[i].active || !PAIR_STATUS[i].id_ok;
            ais_cond = ais_cond || PAIR_STATUS[i].los || PAIR_STATUS[i].loss_of_frame_alignment;
            ais_cond = ais_cond || !PAIR_STATUS[i].active;
        end
    end

    assign rd_req = HSEL && HTRANS[1] && HREADY && !HWRITE;
    assign wr_req = HSEL && HTRANS[1] && HREADY && HWRITE;

    always_ff @(posedge CLK) begin
        if (RST) begin
            cnt_r <= 8'h00;
            seen_r <= 1'b0;
        end else if (CORE_TX.valid) begin
            seen_r <= seen_r || CORE_TX.first;
            cnt_r <= CORE_TX.first ? 8'h01 : cnt_r + 8'h01;
        end
    end

    always_ff @(posedge CLK) begin
        los_cnt_r <= (RST || !APP_LOS) ? 10'h000 : los_cnt_r + {9'h000, los_cnt_r != LOS_SET};
        ais_cnt_r <= (RST || !ais_cond) ? 10'h000 : ais_cnt_r + {9'h000, ais_cnt_r != AIS_SET};
    end

    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (RST);

    sequence read_wait_s;
        !HREADYOUT ##1 HREADYOUT;
    endsequence

    frame_len_a: assert property (
        CORE_TX.valid && seen_r |-> CORE_TX.first == (cnt_r == 8'h90))
        else $error("Core frame start not after 144 bytes.");
    stuff_ones_a: assert property (
        CORE_TX.valid && seen_r && !CORE_TX.first && (cnt_r % 8'h09 == 8'h08)
        |-> CORE_TX.data == 8'hFF) else $error("Stuffing byte not all ones.");
    spare_ones_a: assert property (
        CORE_TX_ZSPARE == 40'hFF_FFFF_FFFF) else $error("Spare overhead bits not ones.");
    bit_rate_a: assert property (
        APP_BIT_EN |=> !APP_BIT_EN ##[60:61] APP_BIT_EN)
        else $error("Application bit enable spacing wrong.");
    oper_up_a: assert property (
        ok |=> SECTION_OPERATIONAL) else $error("Section not operational.");
    oper_down_a: assert property (
        bad |=> !SECTION_OPERATIONAL) else $error("Section not taken down.");
    los_fill_a: assert property (
        CORE_TX.valid && los_cnt_r == LOS_SET |-> CORE_TX.data == 8'hFF)
        else $error("Payload not all ones during input loss.");
    losd_low_a: assert property (
        APP_LOS |=> !CORE_TX_LOSD) else $error("Loss flag not cleared.");
    losd_back_a: assert property (
        !APP_LOS |=> CORE_TX_LOSD) else $error("Loss flag not restored.");
    ais_out_a: assert property (
        ais_cnt_r == AIS_SET |-> APP_TX_DATA) else $error("AIS not sent on pair fault.");
    read_wait_a: assert property (
        rd_req |=> read_wait_s) else $error("Read wait state wrong.");
    write_ready_a: assert property (
        wr_req |=> HREADYOUT) else $error("Write stalled.");
    resp_okay_a: assert property (
        !HRESP) else $error("Response not OKAY.");
    byte_delay_a: assert property (
        CORE_TX.valid && (cnt_r % 8'h09 != 8'h08) |-> $past(APP_BIT_EN))
        else $error("Payload byte not sent right after its last bit.");
endmodule

bind ulm_mapper ulm_mapper_sva #(.N_PAIRS(N_PAIRS)) u_sva (
    .CLK(CLK), .RST(RST), .HSEL(HSEL), .HTRANS(HTRANS), .HWRITE(HWRITE),
    .HREADY(HREADY), .HREADYOUT(HREADYOUT), .HRESP(HRESP), .APP_LOS(APP_LOS),
    .APP_BIT_EN(APP_BIT_EN), .APP_TX_DATA(APP_TX_DATA), .CORE_TX(CORE_TX),
    .CORE_TX_LOSD(CORE_TX_LOSD), .CORE_TX_ZSPARE(CORE_TX_ZSPARE),
    .PAIR_STATUS(PAIR_STATUS), .OTHER_FAIL(OTHER_FAIL),
    .SECTION_OPERATIONAL(SECTION_OPERATIONAL));

// ---- bench/ulm_far_end.sv ----
/* Far-end core model: sends framed bytes and unpacks received frames.
   Assumes the mapper frame of 16 groups of 8 payload and 1 stuffing byte. */
`timescale 1ns/1ps
module ulm_far_end #(
    parameter int unsigned GAP = 434
) (
    input  wire logic               clk,
    input  wire logic               rst,
    input  wire ulm_pkg::ulm_byte_t core_tx,
    output ulm_pkg::ulm_byte_t      core_rx,
    output logic                    pay_v,
    output logic [7:0]              pay_d
);
    int unsigned gap_r;
    int unsigned idx_r;
    int unsigned pos;
    int unsigned pos_r;
    logic [7:0]  val_r;

    assign pos = core_tx.first ? 0 : pos_r;

    always_ff @(posedge clk) begin
        if (rst) begin
            gap_r <= 0;
            idx_r <= 0;
            val_r <= 8'h00;
            core_rx <= '0;
        end else if (gap_r == GAP - 1) begin
            gap_r <= 0;
            core_rx.valid <= 1'b1;
            core_rx.first <= idx_r == 0;
            core_rx.data <= (idx_r % 9 == 8) ? 8'hFF : val_r;
            val_r <= val_r + {7'h00, idx_r % 9 != 8};
            idx_r <= (idx_r == 143) ? 0 : idx_r + 1;
        end else begin
            gap_r <= gap_r + 1;
            core_rx.valid <= 1'b0;
            core_rx.data <= ~core_rx.data;
        end
    end

    always_ff @(posedge clk) begin
        pay_v <= !rst && core_tx.valid && (pos % 9 != 8);
        pay_d <= core_tx.data;
        pos_r <= rst ? 0 : (core_tx.valid ? (pos + 1) % 144 : pos_r);
    end
endmodule

// ---- bench/unstructured_leased_line_mapper_tb.sv ----
/* Self-checking bench for the leased line mapper.
   Assumes the far-end model and the bound port checker. */
`timescale 1ns/1ps
module unstructured_leased_line_mapper_tb;
    logic                          CLK = 1'b0;
    logic                          RST = 1'b1;
    logic                          HSEL = 1'b0;
    logic                          HWRITE = 1'b0;
    logic [31:0]                   HADDR = 32'h0;
    logic [31:0]                   HWDATA = 32'h0;
    logic [1:0]                    HTRANS = 2'h0;
    logic [2:0]                    HSIZE = 3'h2;
    logic                          APP_RX_DATA = 1'b0;
    logic                          APP_LOS = 1'b0;
    logic                          OTHER_FAIL = 1'b0;
    ulm_pkg::ulm_pair_t [1:0]      PAIR_STATUS = 8'h44;
    ulm_pkg::ulm_byte_t            CORE_TX;
    ulm_pkg::ulm_byte_t            CORE_RX;
    logic [31:0]                   HRDATA;
    logic                          HREADYOUT;
    logic                          APP_BIT_EN;
    logic                          APP_TX_DATA;
    logic                          CORE_TX_LOSD;
    logic                          SECTION_OPERATIONAL;
    logic                          IRQ;
    logic                          pay_v;
    logic [7:0]                    pay_d;
    logic [7:0]                    txv, tx_k = 8'h00, last_pay, sh = 8'hFF, rk;
    logic [2:0]                    bi;
    logic [31:0]                   rd;
    logic                          cmp_tx = 1'b1, rx_on = 1'b0, lock = 1'b0;
    int                            fail_count = 0, n_compared = 0, nb = 0;

    always #4 CLK = ~CLK;

    ulm_mapper DUT (.CLK(CLK), .RST(RST), .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS),
        .HWRITE(HWRITE), .HSIZE(HSIZE), .HWDATA(HWDATA), .HREADY(HREADYOUT),
        .HRDATA(HRDATA), .HREADYOUT(HREADYOUT), .HRESP(), .APP_RX_DATA(APP_RX_DATA),
        .APP_LOS(APP_LOS), .APP_BIT_EN(APP_BIT_EN), .APP_TX_DATA(APP_TX_DATA),
        .CORE_TX(CORE_TX), .CORE_TX_LOSD(CORE_TX_LOSD), .CORE_TX_ZSPARE(),
        .CORE_RX(CORE_RX), .PAIR_STATUS(PAIR_STATUS), .OTHER_FAIL(OTHER_FAIL),
        .SECTION_OPERATIONAL(SECTION_OPERATIONAL), .IRQ(IRQ));
    ulm_far_end far (.clk(CLK), .rst(RST), .core_tx(CORE_TX), .core_rx(CORE_RX),
        .pay_v(pay_v), .pay_d(pay_d));

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            fail_count++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        HSEL <= 1'b1;
        HADDR <= {24'h0, a};
        HTRANS <= 2'h2;
        HWRITE <= w;
        @(posedge CLK);
        while (HREADYOUT !== 1'b1) @(posedge CLK);
        HSEL <= 1'b0;
        HTRANS <= 2'h0;
        HWDATA <= d;
        @(posedge CLK);
        while (HREADYOUT !== 1'b1) @(posedge CLK);
        rd = HRDATA;
    endtask

    task automatic rdchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        xfer(1'b0, a, 32'h0);
        check(rd & m, e);
    endtask

    task automatic results();
        $display("compared %0d mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    always @(posedge CLK) begin
        if (RST) begin
            txv = 8'h00;
            bi = 3'h0;
            APP_RX_DATA <= 1'b0;
        end else if (APP_BIT_EN === 1'b1) begin
            txv = txv + {7'h00, bi == 3'h7};
            bi = bi + 3'h1;
            APP_RX_DATA <= txv[3'h7 - bi];
        end
        if (pay_v) begin
            last_pay = pay_d;
            if (cmp_tx) check(pay_d, tx_k);
            tx_k = tx_k + 8'h01;
        end
    end

    always @(negedge CLK) begin
        if (APP_BIT_EN === 1'b1 && rx_on) begin
            sh = {sh[6:0], APP_TX_DATA};
            nb++;
            if (!lock && sh === 8'h00) begin
                lock = 1'b1;
                nb = 0;
                rk = 8'h01;
            end else if (lock && nb == 8) begin
                check(sh, rk);
                rk = rk + 8'h01;
                nb = 0;
            end
        end
    end

    initial begin
        repeat (90000) @(posedge CLK);
        fail_count++;
        results();
    end

    initial begin
        repeat (2) @(posedge CLK);
        RST <= 1'b0;
        repeat (100) @(posedge CLK);
        check(SECTION_OPERATIONAL, 1'b0);
        check(APP_TX_DATA, 1'b1);
        PAIR_STATUS <= 8'hCC;
        repeat (3) @(posedge CLK);
        check(SECTION_OPERATIONAL, 1'b1);
        rx_on <= 1'b1;
        rdchk(8'h00, 32'hFFFF_FFFF, 32'h1);
        rdchk(8'h0C, 32'hFFFF_FFFF, 32'h0);
        xfer(1'b1, 8'h20, 32'hFFFF_FFFF);
        rdchk(8'h20, 32'hFFFF_FFFF, 32'h0);
        xfer(1'b1, 8'h04, 32'h0);
        rdchk(8'h04, 32'h1, 32'h1);
        repeat (63000) @(posedge CLK);
        xfer(1'b1, 8'h0C, 32'h1);
        cmp_tx <= 1'b0;
        APP_LOS <= 1'b1;
        repeat (1100) @(posedge CLK);
        check(CORE_TX_LOSD, 1'b0);
        repeat (600) @(posedge CLK);
        check(last_pay, 8'hFF);
        check(IRQ, 1'b1);
        rdchk(8'h04, 32'h2, 32'h2);
        xfer(1'b1, 8'h08, 32'h1);
        repeat (3) @(posedge CLK);
        check(IRQ, 1'b0);
        APP_LOS <= 1'b0;
        repeat (3) @(posedge CLK);
        check(CORE_TX_LOSD, 1'b1);
        check(IRQ, 1'b0);
        rdchk(8'h08, 32'h3, 32'h2);
        repeat (1200) @(posedge CLK);
        cmp_tx <= 1'b1;
        repeat (1500) @(posedge CLK);
        rx_on <= 1'b0;
        PAIR_STATUS[1].loss_of_frame_alignment <= 1'b1;
        for (int i = 0; i < 4; i++) begin
            repeat (100) @(posedge CLK);
            check(APP_TX_DATA, 1'b1);
        end
        rdchk(8'h04, 32'h4, 32'h4);
        PAIR_STATUS <= 8'hC4;
        repeat (2) @(posedge CLK);
        check(SECTION_OPERATIONAL, 1'b0);
        PAIR_STATUS <= 8'hCC;
        OTHER_FAIL <= 1'b1;
        repeat (2) @(posedge CLK);
        check(SECTION_OPERATIONAL, 1'b0);
        OTHER_FAIL <= 1'b0;
        repeat (2) @(posedge CLK);
        check(SECTION_OPERATIONAL, 1'b1);
        rdchk(8'h10, 32'hFFFF, 32'h1);
        xfer(1'b1, 8'h00, 32'h2);
        repeat (2) begin
            repeat (100) @(posedge CLK);
            check(APP_TX_DATA, 1'b1);
        end
        rdchk(8'h04, 32'h4, 32'h4);
        rdchk(8'h00, 32'h3, 32'h2);
        results();
    end
endmodule
